// ===== hdl/oas_defs.vh
/*
  Constants for the offset, alarm and error-flag register bank.
  Assumes inclusion by oas_regs.v only; holds definitions and nothing else.
*/
`ifndef OAS_DEFS_VH
`define OAS_DEFS_VH

// ----------------------------------------------------------------
// Register indices on the register port
// ----------------------------------------------------------------
`define OAS_IDX_X_ACCEL_OFFSET     4'h0
`define OAS_IDX_Y_ACCEL_OFFSET     4'h1
`define OAS_IDX_X_INCLINE_OFFSET   4'h2
`define OAS_IDX_Y_INCLINE_OFFSET   4'h3
`define OAS_IDX_ROTATION_OFFSET    4'h4
`define OAS_IDX_ALARM_ONE_THR      4'h5
`define OAS_IDX_ALARM_TWO_THR      4'h6
`define OAS_IDX_ALARM_ONE_COUNT    4'h7
`define OAS_IDX_ALARM_TWO_COUNT    4'h8
`define OAS_IDX_ALARM_CONTROL      4'h9
`define OAS_IDX_ERROR_FLAGS        4'hA

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OAS_RST_OFFSET             16'h0000
`define OAS_RST_THRESHOLD          16'h0000
`define OAS_RST_SAMPLE_COUNT       16'h0001
`define OAS_RST_CONTROL            16'h0000
`define OAS_RST_FLAGS              16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OAS_DATA_MSB               13
`define OAS_THR_DIR_BIT            15
`define OAS_COUNT_MSB              7
`define OAS_CTL_SRC2_MSB           15
`define OAS_CTL_SRC2_LSB           12
`define OAS_CTL_SRC1_MSB           11
`define OAS_CTL_SRC1_LSB           8
`define OAS_CTL_RATE2_BIT          6
`define OAS_CTL_RATE1_BIT          5
`define OAS_CTL_FILT2_BIT          4
`define OAS_CTL_FILT1_BIT          3
`define OAS_CTL_IND_EN_BIT         2
`define OAS_CTL_IND_POL_BIT        1
`define OAS_CTL_IND_SEL_BIT        0
`define OAS_FLG_ALARM2_BIT         9
`define OAS_FLG_ALARM1_BIT         8
`define OAS_FLG_SELFTEST_BIT       5
`define OAS_FLG_COMM_BIT           3
`define OAS_FLG_FLASH_BIT          2
`define OAS_FLG_SUPPLY_HI_BIT      1
`define OAS_FLG_SUPPLY_LO_BIT      0

// ----------------------------------------------------------------
// Writable-bit masks (unused bits read as zero)
// ----------------------------------------------------------------
`define OAS_MASK_OFFSET            16'h3FFF
`define OAS_MASK_THRESHOLD         16'hBFFF
`define OAS_MASK_COUNT             16'h00FF
`define OAS_MASK_CONTROL           16'hFF7F

// ----------------------------------------------------------------
// Alarm source codes
// ----------------------------------------------------------------
`define OAS_SRC_OFF                4'h0
`define OAS_SRC_SUPPLY             4'h1
`define OAS_SRC_X_ACCEL            4'h2
`define OAS_SRC_Y_ACCEL            4'h3
`define OAS_SRC_AUX_ADC            4'h4
`define OAS_SRC_TEMP               4'h5
`define OAS_SRC_X_INCLINE          4'h6
`define OAS_SRC_Y_INCLINE          4'h7
`define OAS_SRC_ROTATION           4'h8

// ----------------------------------------------------------------
// Supply limits: millivolts and supply-code weight in microvolts
// ----------------------------------------------------------------
`define OAS_SUPPLY_HI_MV           3625
`define OAS_SUPPLY_LO_MV           2975
`define OAS_SUPPLY_UV_PER_LSB      1000
`define OAS_SUPPLY_HI_CODE  ((`OAS_SUPPLY_HI_MV * 1000) / `OAS_SUPPLY_UV_PER_LSB)
`define OAS_SUPPLY_LO_CODE  ((`OAS_SUPPLY_LO_MV * 1000) / `OAS_SUPPLY_UV_PER_LSB)

`endif

// ===== hdl/oas_regs.v
/*
  Offset, dual-alarm and error-flag register bank of a tilt sensor, with the
  alarm evaluation engine. Assumes a serial front end on core_clk that turns
  host transfers into single-cycle register reads and writes, and a sampler
  that presents raw and filtered data with a one-cycle sampleTick pulse.
*/
// How it works
// - Acceleration offsets are signed 14-bit values, top two bits unused.
// - Incline and rotation offsets are signed 14-bit values in bits 13:0.
// - Two alarm channels run independently with their own settings.
// - Rate mode averages sample differences over the count, then compares.
// - Threshold bit 15 picks greater-than when one, less-than when zero.
// - Threshold bits 13:0 hold the magnitude in the source format.
// - Sample count uses bits 7:0; zero and one both mean one; resets to one.
// - Control bits 15:12 choose alarm two source; zero disables it.
// - Control bits 11:8 choose alarm one source, same encoding.
// - Bits 6 and 5 switch alarm two and one to rate-of-change.
// - Bits 4 and 3 choose filtered data for alarm two and one.
// - Incline and rotation sources always compare filtered data.
// - Control bit 2 routes the alarm condition onto an aux line.
// - Control bit 1 sets indicator polarity, one meaning active high.
// - Control bit 0 picks aux line two when one, line one when zero.
// - Reading the error flag register clears every flag.
// - A persisting condition sets its flag again at the next sample.
// - Flag bits 9 and 8 report alarm two and alarm one.
// - Flag bits 5, 3, 2 report self-test, serial and update failures.
// - Flag bit 1 sets when supply is at or above 3.625 V.
// - Flag bit 0 sets when supply is at or below 2.975 V.
// - Factory restore returns all offset registers to defaults.
`timescale 1ns/10ps
`include "oas_defs.vh"

// ----------------------------------------------------------------
// One alarm channel
// ----------------------------------------------------------------
module oas_alarm_chan
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        sampleTick,
  input  wire        enable,
  input  wire        rateMode,
  input  wire [13:0] value,
  input  wire [15:0] threshold,
  input  wire [7:0]  sampleCount,
  output reg         active
);

  reg signed [13:0] prevVal;
  reg               havePrev;
  reg signed [23:0] accSum;
  reg [7:0]         seen;

  wire signed [13:0] curVal    = value;
  wire signed [13:0] thrMag    = threshold[`OAS_DATA_MSB:0];
  wire               greater   = threshold[`OAS_THR_DIR_BIT];
  wire [7:0]         effCount  = (sampleCount <= 8'h01) ? 8'h01 : sampleCount;
  wire signed [23:0] diffExt   = {{10{curVal[13]}}, curVal} - {{10{prevVal[13]}}, prevVal};
  wire signed [23:0] next_sum  = accSum + diffExt;
  // Comparing the sum against threshold times count avoids a divider.
  wire signed [23:0] thrScaled = {{10{thrMag[13]}}, thrMag} * $signed({16'h0000, effCount});
  wire               staticHit = greater ? (curVal > thrMag) : (curVal < thrMag);
  wire               rateHit   = greater ? (next_sum > thrScaled) : (next_sum < thrScaled);
  wire               lastOne   = ((seen + 8'h01) >= effCount);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevVal  <= 14'h0000;
      havePrev <= 1'b0;
      accSum   <= 24'h000000;
      seen     <= 8'h00;
      active   <= 1'b0;
    end
    else if (!enable)
    begin
      havePrev <= 1'b0;
      accSum   <= 24'h000000;
      seen     <= 8'h00;
      active   <= 1'b0;
    end
    else if (sampleTick)
    begin
      prevVal  <= curVal;
      havePrev <= 1'b1;
      if (!rateMode)
      begin
        accSum <= 24'h000000;
        seen   <= 8'h00;
        active <= staticHit;
      end
      else if (havePrev)
      begin
        if (lastOne)
        begin
          active <= rateHit;
          accSum <= 24'h000000;
          seen   <= 8'h00;
        end
        else
        begin
          accSum <= next_sum;
          seen   <= seen + 8'h01;
        end
      end
    end
  end

endmodule // oas_alarm_chan

// ----------------------------------------------------------------
// Register bank top
// ----------------------------------------------------------------
module oas_regs
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        sampleTick,
  input  wire [13:0] supplyRaw,
  input  wire [13:0] supplyFilt,
  input  wire [13:0] xAccelRaw,
  input  wire [13:0] xAccelFilt,
  input  wire [13:0] yAccelRaw,
  input  wire [13:0] yAccelFilt,
  input  wire [13:0] auxAdcRaw,
  input  wire [13:0] auxAdcFilt,
  input  wire [13:0] tempRaw,
  input  wire [13:0] tempFilt,
  input  wire [13:0] xInclineRaw,
  input  wire [13:0] xInclineFilt,
  input  wire [13:0] yInclineRaw,
  input  wire [13:0] yInclineFilt,
  input  wire [13:0] rotationRaw,
  input  wire [13:0] rotationFilt,
  input  wire        selfTestFail,
  input  wire        commFail,
  input  wire        flashFail,
  input  wire        factoryRestore,
  input  wire [3:0]  regSel,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWrData,
  output reg  [15:0] regRdData,
  output reg  [13:0] xAccelOut,
  output reg  [13:0] yAccelOut,
  output reg  [13:0] xInclineOut,
  output reg  [13:0] yInclineOut,
  output reg  [13:0] rotationOut,
  output reg         auxLineOneOut,
  output reg         auxLineOneOe,
  output reg         auxLineTwoOut,
  output reg         auxLineTwoOe
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [15:0] xAccelOffset;
  reg [15:0] yAccelOffset;
  reg [15:0] xInclineOffset;
  reg [15:0] yInclineOffset;
  reg [15:0] rotationOffset;
  reg [15:0] alarmOneThreshold;
  reg [15:0] alarmTwoThreshold;
  reg [15:0] alarmOneSampleCount;
  reg [15:0] alarmTwoSampleCount;
  reg [15:0] alarmControl;
  reg [15:0] errorFlags;
  reg [15:0] next_flags;
  reg [15:0] rdMux;

  wire       alarmOneActive;
  wire       alarmTwoActive;

  // ----------------------------------------------------------------
  // Offset correction
  // ----------------------------------------------------------------
  // Sums wrap at 14 bits; saturation is left to the sampler.
  wire [13:0] xAccelCorr  = xAccelRaw + xAccelOffset[`OAS_DATA_MSB:0];
  wire [13:0] xAccelCorrF = xAccelFilt + xAccelOffset[`OAS_DATA_MSB:0];
  wire [13:0] yAccelCorr  = yAccelRaw + yAccelOffset[`OAS_DATA_MSB:0];
  wire [13:0] yAccelCorrF = yAccelFilt + yAccelOffset[`OAS_DATA_MSB:0];
  wire [13:0] xInclCorrF  = xInclineFilt + xInclineOffset[`OAS_DATA_MSB:0];
  wire [13:0] yInclCorrF  = yInclineFilt + yInclineOffset[`OAS_DATA_MSB:0];
  wire [13:0] rotCorrF    = rotationFilt + rotationOffset[`OAS_DATA_MSB:0];

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xAccelOut   <= 14'h0000;
      yAccelOut   <= 14'h0000;
      xInclineOut <= 14'h0000;
      yInclineOut <= 14'h0000;
      rotationOut <= 14'h0000;
    end
    else if (sampleTick)
    begin
      xAccelOut   <= xAccelCorr;
      yAccelOut   <= yAccelCorr;
      xInclineOut <= xInclineRaw + xInclineOffset[`OAS_DATA_MSB:0];
      yInclineOut <= yInclineRaw + yInclineOffset[`OAS_DATA_MSB:0];
      rotationOut <= rotationRaw + rotationOffset[`OAS_DATA_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Alarm source selection
  // ----------------------------------------------------------------
  function [13:0] pickSource;
    input [3:0] code;
    input       useFilt;
    input [13:0] sup;
    input [13:0] supF;
    input [13:0] xa;
    input [13:0] xaF;
    input [13:0] ya;
    input [13:0] yaF;
    input [13:0] aux;
    input [13:0] auxF;
    input [13:0] tmp;
    input [13:0] tmpF;
    input [13:0] xiF;
    input [13:0] yiF;
    input [13:0] roF;
    begin
      case (code)
        `OAS_SRC_SUPPLY:    pickSource = useFilt ? supF : sup;
        `OAS_SRC_X_ACCEL:   pickSource = useFilt ? xaF : xa;
        `OAS_SRC_Y_ACCEL:   pickSource = useFilt ? yaF : ya;
        `OAS_SRC_AUX_ADC:   pickSource = useFilt ? auxF : aux;
        `OAS_SRC_TEMP:      pickSource = useFilt ? tmpF : tmp;
        `OAS_SRC_X_INCLINE: pickSource = xiF;
        `OAS_SRC_Y_INCLINE: pickSource = yiF;
        `OAS_SRC_ROTATION:  pickSource = roF;
        default:            pickSource = 14'h0000;
      endcase
    end
  endfunction

  wire [3:0] srcOne = alarmControl[`OAS_CTL_SRC1_MSB:`OAS_CTL_SRC1_LSB];
  wire [3:0] srcTwo = alarmControl[`OAS_CTL_SRC2_MSB:`OAS_CTL_SRC2_LSB];
  // Codes above the documented range behave as disabled.
  wire       enOne  = (srcOne != `OAS_SRC_OFF) && (srcOne <= `OAS_SRC_ROTATION);
  wire       enTwo  = (srcTwo != `OAS_SRC_OFF) && (srcTwo <= `OAS_SRC_ROTATION);

  wire [13:0] valOne = pickSource(srcOne, alarmControl[`OAS_CTL_FILT1_BIT],
    supplyRaw, supplyFilt, xAccelCorr, xAccelCorrF, yAccelCorr, yAccelCorrF,
    auxAdcRaw, auxAdcFilt, tempRaw, tempFilt, xInclCorrF, yInclCorrF, rotCorrF);
  wire [13:0] valTwo = pickSource(srcTwo, alarmControl[`OAS_CTL_FILT2_BIT],
    supplyRaw, supplyFilt, xAccelCorr, xAccelCorrF, yAccelCorr, yAccelCorrF,
    auxAdcRaw, auxAdcFilt, tempRaw, tempFilt, xInclCorrF, yInclCorrF, rotCorrF);

  // ----------------------------------------------------------------
  // Alarm channels
  // ----------------------------------------------------------------
  oas_alarm_chan alarmOne
  (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .sampleTick  (sampleTick),
    .enable      (enOne),
    .rateMode    (alarmControl[`OAS_CTL_RATE1_BIT]),
    .value       (valOne),
    .threshold   (alarmOneThreshold),
    .sampleCount (alarmOneSampleCount[`OAS_COUNT_MSB:0]),
    .active      (alarmOneActive)
  );

  oas_alarm_chan alarmTwo
  (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .sampleTick  (sampleTick),
    .enable      (enTwo),
    .rateMode    (alarmControl[`OAS_CTL_RATE2_BIT]),
    .value       (valTwo),
    .threshold   (alarmTwoThreshold),
    .sampleCount (alarmTwoSampleCount[`OAS_COUNT_MSB:0]),
    .active      (alarmTwoActive)
  );

  // ----------------------------------------------------------------
  // Alarm indicator
  // ----------------------------------------------------------------
  wire alarmAny = alarmOneActive | alarmTwoActive;
  wire indLevel = alarmControl[`OAS_CTL_IND_POL_BIT] ? alarmAny : ~alarmAny;
  wire indOn    = alarmControl[`OAS_CTL_IND_EN_BIT];
  wire indTwo   = alarmControl[`OAS_CTL_IND_SEL_BIT];

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auxLineOneOut <= 1'b0;
      auxLineOneOe  <= 1'b0;
      auxLineTwoOut <= 1'b0;
      auxLineTwoOe  <= 1'b0;
    end
    else
    begin
      auxLineOneOe  <= indOn & ~indTwo;
      auxLineTwoOe  <= indOn & indTwo;
      auxLineOneOut <= indOn & ~indTwo & indLevel;
      auxLineTwoOut <= indOn & indTwo & indLevel;
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  wire supplyHigh = ({18'h00000, supplyRaw} >= `OAS_SUPPLY_HI_CODE);
  wire supplyLow  = ({18'h00000, supplyRaw} <= `OAS_SUPPLY_LO_CODE);

  always @*
  begin
    next_flags = errorFlags;
    if (regRead && (regSel == `OAS_IDX_ERROR_FLAGS))
    begin
      next_flags = 16'h0000;
    end
    // Setting follows clearing so an event in the read cycle is kept.
    if (sampleTick)
    begin
      next_flags[`OAS_FLG_ALARM2_BIT]    = next_flags[`OAS_FLG_ALARM2_BIT] | alarmTwoActive;
      next_flags[`OAS_FLG_ALARM1_BIT]    = next_flags[`OAS_FLG_ALARM1_BIT] | alarmOneActive;
      next_flags[`OAS_FLG_SELFTEST_BIT]  = next_flags[`OAS_FLG_SELFTEST_BIT] | selfTestFail;
      next_flags[`OAS_FLG_COMM_BIT]      = next_flags[`OAS_FLG_COMM_BIT] | commFail;
      next_flags[`OAS_FLG_FLASH_BIT]     = next_flags[`OAS_FLG_FLASH_BIT] | flashFail;
      next_flags[`OAS_FLG_SUPPLY_HI_BIT] = next_flags[`OAS_FLG_SUPPLY_HI_BIT] | supplyHigh;
      next_flags[`OAS_FLG_SUPPLY_LO_BIT] = next_flags[`OAS_FLG_SUPPLY_LO_BIT] | supplyLow;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xAccelOffset        <= `OAS_RST_OFFSET;
      yAccelOffset        <= `OAS_RST_OFFSET;
      xInclineOffset      <= `OAS_RST_OFFSET;
      yInclineOffset      <= `OAS_RST_OFFSET;
      rotationOffset      <= `OAS_RST_OFFSET;
      alarmOneThreshold   <= `OAS_RST_THRESHOLD;
      alarmTwoThreshold   <= `OAS_RST_THRESHOLD;
      alarmOneSampleCount <= `OAS_RST_SAMPLE_COUNT;
      alarmTwoSampleCount <= `OAS_RST_SAMPLE_COUNT;
      alarmControl        <= `OAS_RST_CONTROL;
      errorFlags          <= `OAS_RST_FLAGS;
    end
    else
    begin
      errorFlags <= next_flags;
      if (factoryRestore)
      begin
        xAccelOffset   <= `OAS_RST_OFFSET;
        yAccelOffset   <= `OAS_RST_OFFSET;
        xInclineOffset <= `OAS_RST_OFFSET;
        yInclineOffset <= `OAS_RST_OFFSET;
        rotationOffset <= `OAS_RST_OFFSET;
      end
      else if (regWrite)
      begin
        case (regSel)
          `OAS_IDX_X_ACCEL_OFFSET:   xAccelOffset   <= regWrData & `OAS_MASK_OFFSET;
          `OAS_IDX_Y_ACCEL_OFFSET:   yAccelOffset   <= regWrData & `OAS_MASK_OFFSET;
          `OAS_IDX_X_INCLINE_OFFSET: xInclineOffset <= regWrData & `OAS_MASK_OFFSET;
          `OAS_IDX_Y_INCLINE_OFFSET: yInclineOffset <= regWrData & `OAS_MASK_OFFSET;
          `OAS_IDX_ROTATION_OFFSET:  rotationOffset <= regWrData & `OAS_MASK_OFFSET;
          default:                   xAccelOffset   <= xAccelOffset;
        endcase
      end
      if (regWrite)
      begin
        case (regSel)
          `OAS_IDX_ALARM_ONE_THR:   alarmOneThreshold   <= regWrData & `OAS_MASK_THRESHOLD;
          `OAS_IDX_ALARM_TWO_THR:   alarmTwoThreshold   <= regWrData & `OAS_MASK_THRESHOLD;
          `OAS_IDX_ALARM_ONE_COUNT: alarmOneSampleCount <= regWrData & `OAS_MASK_COUNT;
          `OAS_IDX_ALARM_TWO_COUNT: alarmTwoSampleCount <= regWrData & `OAS_MASK_COUNT;
          `OAS_IDX_ALARM_CONTROL:   alarmControl        <= regWrData & `OAS_MASK_CONTROL;
          default:                  alarmControl        <= alarmControl;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @*
  begin
    case (regSel)
      `OAS_IDX_X_ACCEL_OFFSET:   rdMux = xAccelOffset;
      `OAS_IDX_Y_ACCEL_OFFSET:   rdMux = yAccelOffset;
      `OAS_IDX_X_INCLINE_OFFSET: rdMux = xInclineOffset;
      `OAS_IDX_Y_INCLINE_OFFSET: rdMux = yInclineOffset;
      `OAS_IDX_ROTATION_OFFSET:  rdMux = rotationOffset;
      `OAS_IDX_ALARM_ONE_THR:    rdMux = alarmOneThreshold;
      `OAS_IDX_ALARM_TWO_THR:    rdMux = alarmTwoThreshold;
      `OAS_IDX_ALARM_ONE_COUNT:  rdMux = alarmOneSampleCount;
      `OAS_IDX_ALARM_TWO_COUNT:  rdMux = alarmTwoSampleCount;
      `OAS_IDX_ALARM_CONTROL:    rdMux = alarmControl;
      `OAS_IDX_ERROR_FLAGS:      rdMux = errorFlags;
      default:                   rdMux = 16'h0000;
    endcase
  end

  // Read data is captured with the read strobe so the flag clear cannot race it.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData <= 16'h0000;
    end
    else if (regRead)
    begin
      regRdData <= rdMux;
    end
  end

endmodule // oas_regs

// ===== verif/oas_regs_asserts.sv
/* Port checker for the register bank.
   Assumes binding onto oas_regs, one clock, asynchronous active-low reset. */
`timescale 1ns/10ps
module oas_chk
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        sampleTick,
  input wire logic [3:0]  regSel,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  input wire logic [13:0] xAccelOut,
  input wire logic        auxLineOneOe,
  input wire logic        auxLineTwoOe
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_flagRd;
    regRead && regSel == 4'hA && !sampleTick;
  endsequence
  property p_offTop; regRead && regSel <= 4'h4 |=> regRdData[15:14] == 2'b00; endproperty
  property p_thrGap; regRead && (regSel == 4'h5 || regSel == 4'h6) |=> !regRdData[14]; endproperty
  property p_cntTop; regRead && (regSel == 4'h7 || regSel == 4'h8) |=> regRdData[15:8] == 8'h00;
  endproperty
  property p_ctlGap; regRead && regSel == 4'h9 |=> !regRdData[7]; endproperty
  property p_flagGap; regRead && regSel == 4'hA |=> (regRdData & 16'hFCD0) == 16'h0000; endproperty
  // Two reads with no sample between: the first clears, so the second must see zero.
  property p_clr; s_flagRd ##1 s_flagRd |=> regRdData == 16'h0000; endproperty
  property p_oneLine; !(auxLineOneOe && auxLineTwoOe); endproperty
  property p_hold; !sampleTick |=> $stable(xAccelOut); endproperty
  a_offTop: assert property (p_offTop) else $error("offset unused bits set");
  a_thrGap: assert property (p_thrGap) else $error("threshold bit 14 set");
  a_cntTop: assert property (p_cntTop) else $error("count upper byte set");
  a_ctlGap: assert property (p_ctlGap) else $error("control bit 7 set");
  a_flagGap: assert property (p_flagGap) else $error("flag unused bits set");
  a_clr: assert property (p_clr) else $error("flags not cleared by read");
  a_oneLine: assert property (p_oneLine) else $error("both aux lines driven");
  a_hold: assert property (p_hold) else $error("output moved without sample");
endmodule // oas_chk

bind oas_regs oas_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .sampleTick(sampleTick),
  .regSel(regSel), .regRead(regRead), .regRdData(regRdData), .xAccelOut(xAccelOut),
  .auxLineOneOe(auxLineOneOe), .auxLineTwoOe(auxLineTwoOe));

// ===== verif/oas_host.sv
/* Host model driving the register port with single-word reads and writes.
   Assumes the bank's core_clk; requests change only at rising edges. */
`timescale 1ns/10ps
module oas_host
(
  input  wire logic        core_clk,
  input  wire logic [15:0] regRdData,
  output logic      [3:0]  regSel = 4'h0,
  output logic             regWrite = 1'b0,
  output logic             regRead = 1'b0,
  output logic      [15:0] regWrData = 16'h0000
);
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] idx, input logic [15:0] val);
    @(posedge core_clk)
    begin
      regSel    <= idx;
      regWrData <= val;
      regWrite  <= 1'b1;
    end
    @(posedge core_clk) regWrite <= 1'b0;
  endtask
  // Holding the strobe n cycles gives n back-to-back reads; the last answer is returned.
  task automatic rd(input logic [3:0] idx, input int n, output logic [15:0] val);
    @(posedge core_clk)
    begin
      regSel  <= idx;
      regRead <= 1'b1;
    end
    repeat (n) @(posedge core_clk);
    regRead <= 1'b0;
    #1 val = regRdData;
  endtask
endmodule // oas_host

// ===== verif/testbench.sv
/* Self-checking bench for the register bank.
   Assumes oas_host on the register port and the bound port checker. */
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sampleTick = 1'b0;
  logic [13:0] raw [0:7];
  logic [13:0] filt [0:7];
  logic        selfTestFail = 1'b0, commFail = 1'b0, flashFail = 1'b0, factoryRestore = 1'b0;
  wire  [3:0]  regSel, aux;
  wire         regWrite, regRead;
  wire  [15:0] regWrData, regRdData;
  wire  [13:0] xAccelOut, rotationOut;
  logic [15:0] d;
  int          n_fail = 0, samples_checked = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  oas_regs dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .sampleTick(sampleTick),
    .supplyRaw(raw[0]), .supplyFilt(filt[0]), .xAccelRaw(raw[1]), .xAccelFilt(filt[1]),
    .yAccelRaw(raw[2]), .yAccelFilt(filt[2]), .auxAdcRaw(raw[3]), .auxAdcFilt(filt[3]),
    .tempRaw(raw[4]), .tempFilt(filt[4]), .xInclineRaw(raw[5]), .xInclineFilt(filt[5]),
    .yInclineRaw(raw[6]), .yInclineFilt(filt[6]), .rotationRaw(raw[7]), .rotationFilt(filt[7]),
    .selfTestFail(selfTestFail), .commFail(commFail), .flashFail(flashFail),
    .factoryRestore(factoryRestore), .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .xAccelOut(xAccelOut), .yAccelOut(),
    .xInclineOut(), .yInclineOut(), .rotationOut(rotationOut), .auxLineOneOut(aux[2]),
    .auxLineOneOe(aux[3]), .auxLineTwoOut(aux[0]), .auxLineTwoOe(aux[1])
  );
  oas_host host
  (
    .core_clk(core_clk), .regRdData(regRdData), .regSel(regSel), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] i, input int n, input logic [15:0] e);
    host.rd(i, n, d);
    chk(d, e);
  endtask
  // Outputs and alarm move on the taking edge, the aux pins one edge later.
  task automatic tick;
    @(posedge core_clk) sampleTick <= 1'b1;
    @(posedge core_clk) sampleTick <= 1'b0;
    @(posedge core_clk) #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      raw[i] = 14'h0000;
      filt[i] = 14'h0000;
    end
    raw[0] = 14'h0CE4;
    filt[0] = 14'h0CE4;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++)
      rdc(4'(i), 1, (i == 7 || i == 8) ? 16'h0001 : 16'h0000);
    for (int i = 0; i < 10; i++)
      host.wr(4'(i), 16'hFFFF);
    for (int i = 0; i < 10; i++)
      rdc(4'(i), 1, i < 5 ? 16'h3FFF : i < 7 ? 16'hBFFF : i < 9 ? 16'h00FF : 16'hFF7F);
    rdc(4'hB, 1, 16'h0000);
    @(posedge core_clk) factoryRestore <= 1'b1;
    @(posedge core_clk) factoryRestore <= 1'b0;
    for (int i = 0; i < 6; i++)
      rdc(4'(i), 1, i < 5 ? 16'h0000 : 16'hBFFF);
    host.wr(4'h0, 16'h0005);
    host.wr(4'h4, 16'h3FFE);
    @(posedge core_clk) raw[1] <= 14'h0064;
    raw[7] <= 14'h0064;
    tick();
    chk({2'b00, xAccelOut}, 16'h0069);
    chk({2'b00, rotationOut}, 16'h0062);
    host.wr(4'h0, 16'h0000);
    $display("registers done");
    rdc(4'hA, 2, 16'h0000);
    @(posedge core_clk) raw[0] <= 14'h0E29;
    filt[0] <= 14'h0E29;
    selfTestFail <= 1'b1;
    tick();
    @(posedge core_clk) selfTestFail <= 1'b0;
    rdc(4'hA, 1, 16'h0022);
    rdc(4'hA, 1, 16'h0000);
    tick();
    rdc(4'hA, 1, 16'h0002);
    @(posedge core_clk) raw[0] <= 14'h0B9F;
    filt[0] <= 14'h0B9F;
    commFail <= 1'b1;
    flashFail <= 1'b1;
    tick();
    rdc(4'hA, 1, 16'h000D);
    @(posedge core_clk) raw[0] <= 14'h0CE4;
    filt[0] <= 14'h0CE4;
    commFail <= 1'b0;
    flashFail <= 1'b0;
    $display("flags done");
    host.wr(4'h5, 16'h8032);
    host.wr(4'h9, 16'h0206);
    tick();
    chk({12'h000, aux}, 16'h000C);
    tick();
    rdc(4'hA, 1, 16'h0100);
    host.wr(4'h9, 16'h0205);
    tick();
    chk({12'h000, aux}, 16'h0002);
    host.wr(4'h5, 16'h0032);
    tick();
    chk({12'h000, aux}, 16'h0003);
    host.wr(4'h9, 16'h020D);
    tick();
    chk({12'h000, aux}, 16'h0002);
    // Raw incline stays low so only a filtered comparison can fire.
    @(posedge core_clk) filt[6] <= 14'h00C8;
    host.wr(4'h6, 16'h8064);
    host.wr(4'h9, 16'h7000);
    tick();
    host.rd(4'hA, 1, d);
    tick();
    rdc(4'hA, 1, 16'h0200);
    chk({12'h000, aux}, 16'h0000);
    $display("static alarms done");
    host.wr(4'h9, 16'h0000);
    host.wr(4'h7, 16'h0002);
    host.wr(4'h5, 16'h800A);
    host.wr(4'h9, 16'h0226);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk) raw[1] <= 14'(20 * k);
      tick();
      chk({12'h000, aux}, k == 2 ? 16'h000C : 16'h0008);
    end
    $display("rate alarm done");
    end_of_test();
  end
endmodule // testbench
